/* File: verilog/cfg_readout_pkg.sv */
// shared constants, carriers and state codes for the serial configuration read-out block
package cfg_readout_pkg;

	// ==========================================================
	// array geometry
	localparam int ADDR_W              = 21;
	localparam int MIN_CAPACITY        = 65536;
	localparam int MAX_CAPACITY        = 2097152;
	localparam int DEFAULT_CAPACITY    = 131072;
	localparam int NO_CASCADE_CAPACITY = 65536;
	localparam int PROTECT_BLOCK_BITS  = 4096;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;

	// ==========================================================
	// prefetch buffer
	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================
	// reset polarity setting, kept as a group of stored bytes
	localparam int         POLARITY_BYTES        = 4;
	localparam logic [7:0] POLARITY_DEFAULT_BYTE = 8'hff;
	localparam logic [7:0] POLARITY_INVERT_BYTE  = 8'h5a;

	// ==========================================================
	// pin sampling: bit positions in the sampled pin vector
	localparam int         SYNC_STAGES = 3;
	localparam int         PIN_COUNT   = 5;
	localparam int         PIN_CLK     = 0;
	localparam int         PIN_OE      = 1;
	localparam int         PIN_CS      = 2;
	localparam int         PIN_SER     = 3;
	localparam int         PIN_WP      = 4;
	localparam logic [4:0] PIN_IDLE    = 5'h0c;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic              valid;
		logic              to_polarity;
		logic [1:0]        byte_index;
		logic [7:0]        byte_value;
		logic [ADDR_W-1:0] addr;
		logic              bit_value;
	} prog_req_t;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic              bit_value;
	} mem_wr_t;

	typedef enum logic [3:0] {
		ST_HALT  = 4'h1,
		ST_SHIFT = 4'h2,
		ST_DONE  = 4'h4,
		ST_PROG  = 4'h8
	} readout_state_t;

endpackage

/* File: verilog/bit_fifo.sv */
// small flip-flop fifo with valid/ready on both sides and a synchronous flush
`timescale 1ns/1ps
`default_nettype none

module bit_fifo
	import cfg_readout_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != FULL_COUNT);
	assign out_valid = (count != '0);
	assign out_data  = store[rd_ptr];
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;

	// ==========================================================
	// storage
	always_ff @(posedge clk)
	begin
		if (push)
			store[wr_ptr] <= in_data;
	end

	// ==========================================================
	// pointers and fill level
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/serial_config_memory_readout.sv */
// serial configuration memory read-out control: pins, address counter, cascade and programming
//
// Operation
// (RULE1) reset level on reset/output-enable clears address counter and floats data output
// (RULE2) chip select high after reset keeps counter halted and data floating
// (RULE3) chip select low with reset inactive enables counter and data driver
// (RULE4) reset level resets counter and floats data at any time, whatever chip select
// (RULE5) after last bit and cascade low, data output is released to high impedance
// (RULE6) power-up clears the address counter without any reset pin activity
// (RULE7) reset pin polarity comes from four stored setting bytes
// (RULE8) factory default: low means reset, high means output enable
// (RULE9) single-bit words; capacity per variant from 65,536 to 2,097,152 bits
// (RULE10) chip select and reset/output-enable gate data driver, counter and oscillator
// (RULE11) the FPGA drives chip select, reset/output-enable and the serial clock
// (RULE12) write protection acts only while in programming mode
// (RULE13) in-system programming path is separate from the read-out path
// (RULE14) smallest variant has no cascade output function
// (RULE15) each rising clock edge advances counter and next bit, only when enabled
// (RULE16) cascade output goes low once the counter reaches its maximum
// (RULE17) chip select low at reset release makes this the first memory in chain
// (RULE18) serial program enable held high for loading; low selects programming mode
// (RULE19) counter never wraps at maximum; only reset or power-up restarts it; the code also clears it in programming mode
`timescale 1ns/1ps
`default_nettype none

module serial_config_memory_readout
	import cfg_readout_pkg::*;
#(
	parameter int CAPACITY      = DEFAULT_CAPACITY,
	parameter int PROTECT_BITS  = PROTECT_BLOCK_BITS,
	parameter int BUFFER_DEPTH  = FIFO_DEPTH
)
(
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              config_serial_clock,
	output logic                   clock_drive_out,
	output logic                   clock_drive_oe,
	input  wire logic              reset_oe,
	input  wire logic              chip_select_low,
	input  wire logic              serial_program_enable_low,
	input  wire logic              write_protect,
	output logic                   data_out,
	output logic                   data_oe,
	output logic                   cascade_select_out_low,
	output logic                   oscillator_enable,
	output logic                   first_in_chain,
	output logic                   mem_rd_en,
	output logic      [ADDR_W-1:0] mem_rd_addr,
	input  wire logic              mem_rd_data,
	input  wire prog_req_t         prog_req,
	output mem_wr_t                mem_wr,
	output logic                   prog_refused
);

	localparam logic [ADDR_W-1:0] LAST_ADDR    = ADDR_W'(CAPACITY - 1);
	localparam logic [ADDR_W:0]   FETCH_END    = (ADDR_W + 1)'(CAPACITY);
	localparam logic [ADDR_W-1:0] PROTECT_END  = ADDR_W'(PROTECT_BITS);
	localparam logic              HAS_CASCADE  = (CAPACITY != NO_CASCADE_CAPACITY);

	// a polarity setting counts only when every stored byte carries the code
	function automatic logic all_bytes_match(input logic [7:0] b [POLARITY_BYTES],
		input logic [7:0] code);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < POLARITY_BYTES; i++)
			hit = hit && (b[i] == code);
		return hit;
	endfunction

	// ==========================================================
	// pin sampling
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] sync1;
	logic [PIN_COUNT-1:0] sync2;
	logic [PIN_COUNT-1:0] sync3;
	logic [PIN_COUNT-1:0] pin;

	assign pin_raw = {write_protect, serial_program_enable_low, chip_select_low,
		reset_oe, config_serial_clock};

	// a level is taken once the second and third stages agree; glitches shorter
	// than two cycles never reach the counter
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1 <= PIN_IDLE;
			sync2 <= PIN_IDLE;
			sync3 <= PIN_IDLE;
			pin   <= PIN_IDLE;
		end
		else
		begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin   <= (sync2 & sync3) | (pin & (sync2 | sync3));
		end
	end

	// ==========================================================
	// control decode
	logic [7:0]     polarity_byte [POLARITY_BYTES];
	logic           reset_level_high;
	logic           prog_mode;
	logic           reset_asserted;
	logic           cs_active;
	logic           clk_prev;
	logic           clk_rise;
	logic           reset_prev;
	readout_state_t state;
	logic [ADDR_W-1:0] bit_index;
	logic           at_last;
	logic           advance;

	assign reset_level_high = all_bytes_match(polarity_byte, POLARITY_INVERT_BYTE); // [RULE7]
	assign prog_mode        = !pin[PIN_SER];                                        // [RULE18]
	assign reset_asserted   = !prog_mode && (pin[PIN_OE] == reset_level_high);     // [RULE8]
	assign cs_active        = !pin[PIN_CS];
	assign clk_rise         = pin[PIN_CLK] && !clk_prev;
	assign at_last          = (bit_index == LAST_ADDR);
	assign advance          = clk_rise && (state == ST_SHIFT) && !at_last;          // [RULE15]

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			clk_prev   <= 1'b0;
			reset_prev <= 1'b1;
		end
		else
		begin
			clk_prev   <= pin[PIN_CLK];
			reset_prev <= reset_asserted || prog_mode;
		end
	end

	// chain position is caught on the release of reset
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			first_in_chain <= 1'b0;
		else if (reset_prev && !reset_asserted && !prog_mode)
			first_in_chain <= cs_active;                                        // [RULE17]
	end

	// ==========================================================
	// read-out sequencing
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state <= ST_HALT;                                                   // [RULE6]
		else if (prog_mode)
			state <= ST_PROG;                                                   // [RULE13]
		else if (reset_asserted)
			state <= ST_HALT;                                                   // [RULE1] [RULE4]
		else
		begin
			case (state)
				ST_HALT:
					if (cs_active)
						state <= ST_SHIFT;                                      // [RULE3]
				ST_SHIFT:
					if (clk_rise && at_last)
						state <= ST_DONE;
					else if (!cs_active)
						state <= ST_HALT;                                       // [RULE2]
				ST_DONE:
					state <= ST_DONE;
				ST_PROG:
					state <= ST_HALT;
				default:
					state <= ST_HALT;
			endcase
		end
	end

	// address counter: holds at the top instead of wrapping
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			bit_index <= ADDR_RESET;                                            // [RULE6]
		else if (reset_asserted || prog_mode)
			bit_index <= ADDR_RESET;                                            // [RULE1] [RULE4]
		else if (advance)
			bit_index <= bit_index + 1'b1;                                      // [RULE15] [RULE19]
	end

	// ==========================================================
	// prefetch path: memory -> fifo -> data register
	logic [ADDR_W:0] fetch_addr;
	logic            fetch_live;
	logic            flush;
	logic            fifo_in_ready;
	logic            fifo_out_valid;
	logic            fifo_out_data;
	logic            primed;
	logic            pop;

	assign flush       = reset_asserted || prog_mode;
	assign mem_rd_en   = !flush && !fetch_live && fifo_in_ready
		&& (fetch_addr < FETCH_END);                                           // [RULE9]
	assign mem_rd_addr = fetch_addr[ADDR_W-1:0];
	assign pop         = fifo_out_valid && (!primed || advance);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fetch_addr <= '0;
			fetch_live <= 1'b0;
		end
		else
		begin
			fetch_live <= mem_rd_en;
			if (flush)
				fetch_addr <= '0;
			else if (mem_rd_en)
				fetch_addr <= fetch_addr + 1'b1;
		end
	end

	bit_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (BUFFER_DEPTH)
	) prefetch (
		.clk       (clk),
		.nrst      (nrst),
		.flush     (flush),
		.in_valid  (fetch_live),
		.in_ready  (fifo_in_ready),
		.in_data   (mem_rd_data),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out_data)
	);

	// the current bit is held here; an edge that finds the buffer empty leaves the
	// register unprimed so the late bit is loaded as soon as it arrives
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			data_out <= 1'b0;
			primed   <= 1'b0;
		end
		else if (flush)
			primed <= 1'b0;
		else if (pop)
		begin
			data_out <= fifo_out_data;                                          // [RULE15]
			primed   <= 1'b1;
		end
		else if (advance)
			primed <= 1'b0;
	end

	// ==========================================================
	// pin drivers
	// data drives only while shifting; done and halt both float it
	assign data_oe           = (state == ST_SHIFT);                             // [RULE2] [RULE5] [RULE10]
	assign oscillator_enable = !reset_asserted && !prog_mode && cs_active;      // [RULE10]
	assign clock_drive_out   = 1'b0;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cascade_select_out_low <= 1'b1;
		else if (reset_asserted || prog_mode)
			cascade_select_out_low <= 1'b1;
		else if (state == ST_SHIFT && clk_rise && at_last)
			cascade_select_out_low <= !HAS_CASCADE;                             // [RULE16] [RULE14]
	end

	// the first memory pulls the clock low while in reset or after its last bit, outside programming mode
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			clock_drive_oe <= 1'b0;
		else
			clock_drive_oe <= first_in_chain && !prog_mode &&
				(reset_asserted || state == ST_DONE);
	end

	// ==========================================================
	// programming port
	logic prog_protected;

	assign prog_protected = pin[PIN_WP] && cs_active && (prog_req.addr < PROTECT_END); // [RULE12]

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < POLARITY_BYTES; i++)
				polarity_byte[i] <= POLARITY_DEFAULT_BYTE;                      // [RULE8]
		end
		else if (prog_mode && prog_req.valid && prog_req.to_polarity)
			polarity_byte[prog_req.byte_index] <= prog_req.byte_value;         // [RULE7]
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mem_wr       <= '0;
			prog_refused <= 1'b0;
		end
		else
		begin
			mem_wr.en        <= 1'b0;
			prog_refused     <= 1'b0;
			mem_wr.addr      <= prog_req.addr;
			mem_wr.bit_value <= prog_req.bit_value;
			if (prog_req.valid && !prog_req.to_polarity)
			begin
				if (prog_mode && !prog_protected && prog_req.addr <= LAST_ADDR)
					mem_wr.en <= 1'b1;                                          // [RULE13]
				else
					prog_refused <= 1'b1;                                       // [RULE12]
			end
			else if (prog_req.valid && !prog_mode)
				prog_refused <= 1'b1;
		end
	end

endmodule

`default_nettype wire

/* File: tb/cfg_readout_chk.sv */
// pin-level assertions for the serial configuration read-out block
`timescale 1ns/1ps
`default_nettype none

module cfg_readout_chk
	import cfg_readout_pkg::*;
#(
	parameter int CAPACITY     = DEFAULT_CAPACITY,
	parameter int PROTECT_BITS = PROTECT_BLOCK_BITS
)
(
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              config_serial_clock,
	input wire logic              reset_oe,
	input wire logic              chip_select_low,
	input wire logic              serial_program_enable_low,
	input wire logic              write_protect,
	input wire logic              data_out,
	input wire logic              data_oe,
	input wire logic              cascade_select_out_low,
	input wire logic              oscillator_enable,
	input wire logic              mem_rd_en,
	input wire logic [ADDR_W-1:0] mem_rd_addr,
	input wire prog_req_t         prog_req,
	input wire mem_wr_t           mem_wr,
	input wire logic              prog_refused
);
	// ==========================================================
	// polarity tracking, so the reset level is known after a rewrite
	logic [3:0] pol_inv;
	logic       in_reset;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pol_inv <= 4'h0;
		else if (prog_req.valid && prog_req.to_polarity && !serial_program_enable_low)
			pol_inv[prog_req.byte_index] <= (prog_req.byte_value == POLARITY_INVERT_BYTE);
	end
	assign in_reset = (reset_oe == &pol_inv);

	// ==========================================================
	// assertions; eight-cycle runs cover the pin synchroniser latency
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_reset_floats: assert property (in_reset[*8] |-> !data_oe)
		else $error("data driven while reset held");
	a_deselect_floats: assert property (chip_select_low[*8] |->
		!data_oe && !oscillator_enable)
		else $error("data or oscillator on while deselected");
	a_enable_follows: assert property ((!chip_select_low && !in_reset
		&& serial_program_enable_low && cascade_select_out_low)[*8]
		|-> data_oe && oscillator_enable)
		else $error("selected and enabled but not driving");
	a_prog_quiet: assert property (!serial_program_enable_low[*8] |->
		!data_oe && !oscillator_enable)
		else $error("read-out active in programming mode");
	a_last_release: assert property ($fell(cascade_select_out_low) |-> !data_oe)
		else $error("data still driven after cascade went low");
	a_no_wrap: assert property ((!cascade_select_out_low && !in_reset
		&& serial_program_enable_low)[*8] |=> !cascade_select_out_low && !data_oe)
		else $error("read-out restarted without reset");
	a_rd_range: assert property (mem_rd_en |-> mem_rd_addr < CAPACITY ##1 !mem_rd_en)
		else $error("array read out of range or too close");
	a_bit_holds: assert property ((data_oe && !config_serial_clock)[*8]
		##1 !config_serial_clock |-> $stable(data_out))
		else $error("data bit changed without a clock rise");
	a_wr_echo: assert property (mem_wr.en |-> $past(prog_req.valid)
		&& mem_wr.addr == $past(prog_req.addr) && mem_wr.bit_value == $past(prog_req.bit_value))
		else $error("array write does not match request");
	a_one_answer: assert property (prog_req.valid && !prog_req.to_polarity |=>
		mem_wr.en != prog_refused)
		else $error("write request not answered once");
	a_wr_range: assert property (prog_req.valid && prog_req.addr > CAPACITY - 1 |=>
		!mem_wr.en)
		else $error("write beyond capacity accepted");
	a_wp_block: assert property ((write_protect && !chip_select_low)[*8] ##0
		(prog_req.valid && prog_req.addr < PROTECT_BITS) |=> !mem_wr.en)
		else $error("protected block written");
endmodule

`default_nettype wire

/* File: tb/fpga_loader_model.sv */
// master-serial loader model: drives the control pins and link clock, samples data
`timescale 1ns/1ps
`default_nettype none

module fpga_loader_model
(
	input  wire logic clk,
	input  wire logic data_out,
	input  wire logic data_oe,
	output logic      config_serial_clock,
	output logic      reset_oe,
	output logic      chip_select_low
);
	logic got[$];
	logic last;

	initial
	begin
		config_serial_clock = 1'b0;
		reset_oe = 1'b0;
		chip_select_low = 1'b1;
		last = 1'b0;
	end

	// all three control pins come from this loader alone
	task automatic set_pins(input logic oe, input logic cs);
		@(posedge clk);
		reset_oe <= oe;
		chip_select_low <= cs;
	endtask

	// clock stands low between frames; 8 cycles per half period gives 160 ns
	task automatic clock_bits(input int n);
		repeat (n)
		begin
			repeat (8) @(posedge clk);
			// a released line has no pull: show the inverse of the last level
			last = data_oe ? data_out : ~last;
			got.push_back(last);
			config_serial_clock <= 1'b1;
			repeat (8) @(posedge clk);
			config_serial_clock <= 1'b0;
		end
	endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the read-out block
`timescale 1ns/1ps
`default_nettype none

module testbench
	import cfg_readout_pkg::*;
;
	localparam int CAP = 32;
	localparam int PBITS = 8;
	logic              clk = 1'b0;
	logic              nrst;
	logic              serial_program_enable_low;
	logic              write_protect;
	logic              mem_rd_data = 1'b0;
	logic              data_out;
	logic              data_oe;
	logic              cascade_select_out_low;
	logic              oscillator_enable;
	logic              first_in_chain;
	logic              clock_drive_out;
	logic              clock_drive_oe;
	logic              mem_rd_en;
	logic              prog_refused;
	logic              config_serial_clock;
	logic              reset_oe;
	logic              chip_select_low;
	logic [ADDR_W-1:0] mem_rd_addr;
	prog_req_t         prog_req;
	mem_wr_t           mem_wr;
	logic              pattern[CAP];
	int                fails;
	int                n_compared;

	always #5 clk = ~clk;

	serial_config_memory_readout #(.CAPACITY(CAP), .PROTECT_BITS(PBITS), .BUFFER_DEPTH(16)) DUT (
		.clk(clk), .nrst(nrst), .config_serial_clock(config_serial_clock),
		.clock_drive_out(clock_drive_out), .clock_drive_oe(clock_drive_oe), .reset_oe(reset_oe),
		.chip_select_low(chip_select_low), .serial_program_enable_low(serial_program_enable_low),
		.write_protect(write_protect), .data_out(data_out), .data_oe(data_oe),
		.cascade_select_out_low(cascade_select_out_low), .oscillator_enable(oscillator_enable),
		.first_in_chain(first_in_chain), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data), .prog_req(prog_req), .mem_wr(mem_wr), .prog_refused(prog_refused)
	);

	fpga_loader_model loader (
		.clk(clk), .data_out(data_out), .data_oe(data_oe), .config_serial_clock(config_serial_clock),
		.reset_oe(reset_oe), .chip_select_low(chip_select_low)
	);

	// bit array answers one cycle after the read strobe
	always @(posedge clk)
		mem_rd_data <= pattern[mem_rd_addr[4:0]];

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("BAD t=%0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic read_bits(input int n);
		loader.got.delete();
		loader.clock_bits(n);
		for (int k = 0; k < n; k++)
			chk(loader.got[k], pattern[k]);
	endtask

	task automatic prog(input logic pol, input logic [7:0] v, input logic [ADDR_W-1:0] a,
		input logic wr);
		@(posedge clk);
		prog_req <= {1'b1, pol, a[1:0], v, a, v[0]};
		@(posedge clk);
		prog_req.valid <= 1'b0;
		#1;
		chk(mem_wr.en, wr);
		// a polarity byte is refused only outside programming mode
		chk(prog_refused, !wr && (!pol || serial_program_enable_low));
		if (wr)
			chk(mem_wr.addr, a);
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		int n;
		nrst = 1'b0;
		serial_program_enable_low = 1'b1;
		write_protect = 1'b0;
		prog_req = '0;
		fails = 0;
		n_compared = 0;
		n = $urandom(63);
		for (int k = 0; k < CAP; k++)
			pattern[k] = 1'($urandom);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		settle(8);
		chk(data_oe, 1'b0);
		loader.set_pins(1'b1, 1'b1);
		settle(8);
		chk(data_oe, 1'b0);
		chk(oscillator_enable, 1'b0);
		chk(first_in_chain, 1'b0);
		loader.clock_bits(3);
		chk(data_oe, 1'b0);
		loader.set_pins(1'b1, 1'b0);
		settle(8);
		chk(data_oe, 1'b1);
		chk(oscillator_enable, 1'b1);
		read_bits(CAP);
		settle(8);
		chk(data_oe, 1'b0);
		chk(cascade_select_out_low, 1'b0);
		chk(clock_drive_oe, 1'b0);
		chk(clock_drive_out, 1'b0);
		loader.clock_bits(3);
		chk(data_oe, 1'b0);
		chk(cascade_select_out_low, 1'b0);
		// ==========================================================
		// resets after the full read-out, then in mid-stream at random depths, chip select held low
		for (int r = 0; r < 3; r++)
		begin
			loader.set_pins(1'b0, 1'b0);
			settle(8);
			chk(data_oe, 1'b0);
			// only a memory that came out of reset as first holds the clock low
			chk(clock_drive_oe, r != 0);
			loader.set_pins(1'b1, 1'b0);
			settle(8);
			chk(first_in_chain, 1'b1);
			read_bits(1 + int'($urandom % (CAP - 2)));
		end
		// ==========================================================
		// programming mode, protection and polarity
		@(posedge clk);
		serial_program_enable_low <= 1'b0;
		write_protect <= 1'b1;
		settle(10);
		prog(1'b0, 8'($urandom), ADDR_W'(PBITS + $urandom % (CAP - PBITS)), 1'b1);
		prog(1'b0, 8'h01, ADDR_W'(PBITS - 1), 1'b0);
		prog(1'b0, 8'h00, ADDR_W'(CAP), 1'b0);
		loader.set_pins(1'b1, 1'b1);
		settle(8);
		prog(1'b0, 8'h01, ADDR_W'(0), 1'b1);
		for (int k = 0; k < POLARITY_BYTES; k++)
			prog(1'b1, POLARITY_INVERT_BYTE, ADDR_W'(k), 1'b0);
		@(posedge clk);
		serial_program_enable_low <= 1'b1;
		write_protect <= 1'b0;
		loader.set_pins(1'b0, 1'b0);
		settle(8);
		chk(data_oe, 1'b1);
		chk(data_out, pattern[0]);
		loader.set_pins(1'b1, 1'b0);
		settle(8);
		chk(data_oe, 1'b0);
		prog(1'b0, 8'h01, ADDR_W'(PBITS + 1), 1'b0);
		prog(1'b1, 8'h00, ADDR_W'(0), 1'b0);
		// ==========================================================
		// power-up again: default polarity and counter back at zero
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		settle(10);
		chk(data_oe, 1'b1);
		read_bits(4);
		final_report();
	end

	// the sequence needs some 1,600 cycles, at most about 2,300; allow over thirteen times that
	initial
	begin
		repeat (30000) @(posedge clk);
		fails++;
		final_report();
	end
endmodule

bind serial_config_memory_readout cfg_readout_chk #(.CAPACITY(CAPACITY), .PROTECT_BITS(PROTECT_BITS)) chk_i (
	.clk(clk), .nrst(nrst), .config_serial_clock(config_serial_clock), .reset_oe(reset_oe),
	.chip_select_low(chip_select_low), .serial_program_enable_low(serial_program_enable_low),
	.write_protect(write_protect), .data_out(data_out), .data_oe(data_oe),
	.cascade_select_out_low(cascade_select_out_low), .oscillator_enable(oscillator_enable),
	.mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .prog_req(prog_req), .mem_wr(mem_wr),
	.prog_refused(prog_refused)
);

`default_nettype wire
